// >>> core/cwr_pkg.sv
// package for the configuration word decode and reset combiner
// assumes a single 20 MHz system clock; no imports are used anywhere
package cwr_pkg;
  // nonvolatile word locations (program memory addresses)
  localparam logic [15:0] CONFIG_WORD_ADDR = 16'h2007;
  localparam logic [15:0] CALIB_WORD_ADDR = 16'h2009;
  // configuration word field positions
  localparam int FCM_BIT = 11;
  localparam int SWITCHOVER_BIT = 10;
  localparam int BOR_SEL_HI = 9;
  localparam int BOR_SEL_LO = 8;
  localparam int DATA_PROT_BIT = 7;
  localparam int PROG_PROT_BIT = 6;
  localparam int PIN_EN_BIT = 5;
  localparam int POWERUP_DELAY_TIMER_DIS_BIT = 4;
  localparam int WDT_FORCE_BIT = 3;
  localparam int OSC_SEL_HI = 2;
  localparam int OSC_SEL_LO = 0;
  // erased word: every fuse unprogrammed reads one
  localparam logic [15:0] CONFIG_ERASED = 16'hffff;
  localparam logic [13:0] CALIB_ERASED = 14'h3fff;
  // brown-out select encodings
  typedef enum logic [1:0] {
    CWR_BOR_OFF = 2'h0,
    CWR_BOR_SOFT = 2'h1,
    CWR_BOR_RUN = 2'h2,
    CWR_BOR_ON = 2'h3
  } cwr_bor_t;
  // clock source encodings
  typedef enum logic [2:0] {
    CWR_OSC_LP = 3'h0,
    CWR_OSC_XT = 3'h1,
    CWR_OSC_HS = 3'h2,
    CWR_OSC_EC = 3'h3,
    CWR_OSC_INTIO = 3'h4,
    CWR_OSC_INTCLK = 3'h5,
    CWR_OSC_RESISTOR_CAP_OSC_NO_CLKOUT = 3'h6,
    CWR_OSC_RCCLK = 3'h7
  } cwr_osc_t;
  // reset pin filter: minimum accepted low pulse
  localparam int FILTER_NS = 2000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_W = 6;
  // release synchroniser depth
  localparam int REL_STAGES = 2;
  // reset kind codes reported with the flags
  typedef enum logic [2:0] {
    CWR_RK_POR = 3'h0,
    CWR_RK_BOR = 3'h1,
    CWR_RK_WDT = 3'h3,
    CWR_RK_PIN = 3'h2,
    CWR_RK_PIN_SLEEP = 3'h6,
    CWR_RK_WDT_WAKE = 3'h7
  } cwr_rk_t;
endpackage : cwr_pkg

// >>> core/cwr_config_reset.sv
// configuration word decoder and chip reset combiner
// assumes: por_n comes from the analogue power-on cell and drives reset_n too;
// pin, watchdog and brown-out inputs are asynchronous and are synchronised here
//
// Summary of operation
// - programmed fuse reads zero, unprogrammed reads one
// - configuration word lives at 2007h, decoded there
// - bit 11 enables clock-failure monitor
// - bit 10 enables clock switchover mode
// - bits 9-8 select brown-out mode
// - bits 7/6 zero protect data/program memory
// - bit 4 one disables power-up delay timer
// - bit 3 forces watchdog, else software enable
// - internal/RC oscillator stops while pin reset
// - calibration word at 2009h survives bulk erase
// - reset events reset registers; some keep value
// - watchdog wake-up resumes, no register reset
// - timeout/powerdown flags record reset kind
// - reset pin filter rejects short pulses
// - watchdog reset never drives reset pin
// - pin enable zero: internal reset, pin input
// - pin enable one: reset input with pull-up
// - select 01: software bit gates brown-out
// - select 10: software bit ignored
// - power-on flag zero after power-on only
`timescale 1ns/100ps
`default_nettype none
module cwr_config_reset (
  input wire logic sys_clk,
  input wire logic reset_n,
  // programmer interface to the nonvolatile words
  input wire logic prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  input wire logic prog_bulk_erase,
  output logic [15:0] prog_rdata,
  // shared reset pin, sampled asynchronously
  input wire logic shared_input_pin,
  // reset sources and core state
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic core_sleeping,
  input wire logic soft_brownout_enable,
  input wire logic soft_watchdog_enable,
  input wire logic por_flag_write,
  input wire logic por_flag_wdata,
  input wire logic status_clear,
  // decoded options
  output logic clock_fail_monitor_enable,
  output logic clock_switchover_enable,
  output logic brownout_active,
  output logic data_read_protect,
  output logic prog_read_protect,
  output logic data_eeprom_erase,
  output logic powerup_delay_enable,
  output logic watchdog_active,
  output logic [2:0] clock_mode,
  output logic osc_in_pin_is_io,
  output logic osc_out_pin_is_io,
  output logic clkout_enable,
  output logic internal_osc_stop,
  output logic pin_pullup_enable,
  output logic pin_reset_drive_oe_n,
  output logic pin_digital_in,
  output logic [13:0] calib_word,
  // reset outputs and status
  output logic chip_reset_n,
  output logic wake_resume,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic por_flag_n,
  output logic [2:0] reset_kind
);

  logic [15:0] cfg_ff; // configuration fuses, unprogrammed = one
  logic [13:0] cal_ff; // calibration fuses
  logic [1:0] pin_sync_ff; // reset pin synchroniser
  logic [1:0] wdt_sync_ff; // watchdog timeout synchroniser
  logic [1:0] bod_sync_ff; // brown-out detect synchroniser
  logic [1:0] slp_sync_ff; // sleep state, same clock, registered
  // filter width and limit come first: the counter below is sized by them
  localparam int FILTER_W_L = cwr_pkg::FILTER_W;
  localparam logic [FILTER_W_L-1:0] FILTER_MAX = FILTER_W_L'(cwr_pkg::FILTER_CYCLES);
  logic [FILTER_W_L-1:0] flt_cnt_ff; // low pulse width counter
  logic pin_rst_ff; // filtered pin reset request
  logic [cwr_pkg::REL_STAGES-1:0] rel_ff; // release shift chain
  logic src_rst; // any active reset source
  logic bor_en; // brown-out gate after mode decode
  logic wdt_en; // watchdog gate
  logic erase_ff;
  logic to_ff;
  logic pd_ff;
  logic por_ff;
  logic [2:0] kind_ff;
  logic wake_ff;
  logic wdt_seen_ff; // edge detect on synchronised watchdog

  // field extractors used by several decodes
  function automatic logic [1:0] cwr_bor_field(input logic [15:0] w);
    cwr_bor_field = w[cwr_pkg::BOR_SEL_HI:cwr_pkg::BOR_SEL_LO];
  endfunction : cwr_bor_field

  function automatic logic cwr_is_int_or_rc(input logic [2:0] m);
    cwr_is_int_or_rc = (m >= cwr_pkg::CWR_OSC_INTIO);
  endfunction : cwr_is_int_or_rc

  // fuse store: programmer writes load the whole word, erase returns to ones
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ff <= cwr_pkg::CONFIG_ERASED;
      erase_ff <= 1'b0;
    end
    else
    begin
      erase_ff <= 1'b0;
      if (prog_bulk_erase)
      begin
        cfg_ff <= cwr_pkg::CONFIG_ERASED;
        erase_ff <= !cfg_ff[cwr_pkg::DATA_PROT_BIT];
      end
      else if (prog_we && prog_addr == cwr_pkg::CONFIG_WORD_ADDR)
      begin
        cfg_ff <= prog_wdata;
        // protection going from on to off wipes the data memory
        erase_ff <= !cfg_ff[cwr_pkg::DATA_PROT_BIT] && prog_wdata[cwr_pkg::DATA_PROT_BIT];
      end
    end
  end

  // calibration word: untouched by bulk erase
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cal_ff <= cwr_pkg::CALIB_ERASED;
    else if (prog_we && prog_addr == cwr_pkg::CALIB_WORD_ADDR)
      cal_ff <= prog_wdata[13:0];
  end

  // programmer readback; other addresses read zero
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      prog_rdata <= 16'h0000;
    else if (prog_addr == cwr_pkg::CONFIG_WORD_ADDR)
      prog_rdata <= cfg_ff;
    else if (prog_addr == cwr_pkg::CALIB_WORD_ADDR)
      prog_rdata <= {2'h0, cal_ff};
    else
      prog_rdata <= 16'h0000;
  end

  // input synchronisers; first stage read only by the second
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sync_ff <= 2'h3;
      wdt_sync_ff <= 2'h0;
      bod_sync_ff <= 2'h0;
      slp_sync_ff <= 2'h0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[0], shared_input_pin};
      wdt_sync_ff <= {wdt_sync_ff[0], watchdog_timeout};
      bod_sync_ff <= {bod_sync_ff[0], brownout_detect};
      slp_sync_ff <= {slp_sync_ff[0], core_sleeping};
    end
  end

  // brown-out and watchdog gating from the decoded mode
  always_comb
  begin
    unique case (cwr_bor_field(cfg_ff))
      cwr_pkg::CWR_BOR_ON: bor_en = 1'b1;
      cwr_pkg::CWR_BOR_RUN: bor_en = !slp_sync_ff[1];
      cwr_pkg::CWR_BOR_SOFT: bor_en = soft_brownout_enable;
      cwr_pkg::CWR_BOR_OFF: bor_en = 1'b0;
    endcase
    wdt_en = cfg_ff[cwr_pkg::WDT_FORCE_BIT] || soft_watchdog_enable;
  end

  // noise filter: pin must stay low for the full count
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flt_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end
    else if (!cfg_ff[cwr_pkg::PIN_EN_BIT] || pin_sync_ff[1])
    begin
      // pin released or function tied off: restart the count
      flt_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end
    else if (flt_cnt_ff < FILTER_MAX)
      flt_cnt_ff <= flt_cnt_ff + 1'b1;
    else
      pin_rst_ff <= 1'b1;
  end

  // watchdog event: reset while running, wake-up while sleeping
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      wdt_seen_ff <= 1'b0;
    else
      wdt_seen_ff <= wdt_sync_ff[1];
  end

  // combined source; wake-up is not a reset source
  assign src_rst = pin_rst_ff || (bor_en && bod_sync_ff[1])
    || (wdt_en && wdt_sync_ff[1] && !slp_sync_ff[1]);

  // async assert on reset_n, clocked assert on a reset source, sync release of the chip reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rel_ff <= '0;
    else if (src_rst)
      rel_ff <= '0;
    else
      rel_ff <= {rel_ff[cwr_pkg::REL_STAGES-2:0], 1'b1};
  end

  // status flags per reset kind; active low like the originals
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
      por_ff <= 1'b0;
      kind_ff <= cwr_pkg::CWR_RK_POR;
      wake_ff <= 1'b0;
    end
    else
    begin
      wake_ff <= 1'b0;
      if (wdt_en && wdt_sync_ff[1] && !wdt_seen_ff && slp_sync_ff[1])
      begin
        to_ff <= 1'b0;
        pd_ff <= 1'b0;
        wake_ff <= 1'b1;
        kind_ff <= cwr_pkg::CWR_RK_WDT_WAKE;
      end
      else if (wdt_en && wdt_sync_ff[1] && !wdt_seen_ff)
      begin
        to_ff <= 1'b0;
        kind_ff <= cwr_pkg::CWR_RK_WDT;
      end
      else if (bor_en && bod_sync_ff[1])
      begin
        to_ff <= 1'b1;
        pd_ff <= 1'b1;
        kind_ff <= cwr_pkg::CWR_RK_BOR;
      end
      else if (pin_rst_ff && slp_sync_ff[1])
      begin
        to_ff <= 1'b1;
        pd_ff <= 1'b0;
        kind_ff <= cwr_pkg::CWR_RK_PIN_SLEEP;
      end
      else if (pin_rst_ff)
        kind_ff <= cwr_pkg::CWR_RK_PIN; // flags unchanged
      else if (status_clear)
      begin
        // software acknowledge restores both flags
        to_ff <= 1'b1;
        pd_ff <= 1'b1;
      end
      // power-on flag kept on all but power-on; software sets it
      if (por_flag_write)
        por_ff <= por_flag_wdata;
    end
  end

  // registered decode outputs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clock_fail_monitor_enable <= 1'b0;
      clock_switchover_enable <= 1'b0;
      brownout_active <= 1'b0;
      data_read_protect <= 1'b0;
      prog_read_protect <= 1'b0;
      data_eeprom_erase <= 1'b0;
      powerup_delay_enable <= 1'b0;
      watchdog_active <= 1'b0;
      clock_mode <= cwr_pkg::CWR_OSC_RCCLK;
      osc_in_pin_is_io <= 1'b0;
      osc_out_pin_is_io <= 1'b0;
      clkout_enable <= 1'b0;
      internal_osc_stop <= 1'b0;
      pin_pullup_enable <= 1'b0;
      pin_reset_drive_oe_n <= 1'b1;
      pin_digital_in <= 1'b1;
      calib_word <= cwr_pkg::CALIB_ERASED;
      chip_reset_n <= 1'b0;
      wake_resume <= 1'b0;
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
      por_flag_n <= 1'b0;
      reset_kind <= cwr_pkg::CWR_RK_POR;
    end
    else
    begin
      clock_fail_monitor_enable <= cfg_ff[cwr_pkg::FCM_BIT];
      clock_switchover_enable <= cfg_ff[cwr_pkg::SWITCHOVER_BIT];
      brownout_active <= bor_en;
      data_read_protect <= !cfg_ff[cwr_pkg::DATA_PROT_BIT];
      prog_read_protect <= !cfg_ff[cwr_pkg::PROG_PROT_BIT];
      data_eeprom_erase <= erase_ff;
      powerup_delay_enable <= !cfg_ff[cwr_pkg::POWERUP_DELAY_TIMER_DIS_BIT];
      watchdog_active <= wdt_en;
      clock_mode <= cfg_ff[cwr_pkg::OSC_SEL_HI:cwr_pkg::OSC_SEL_LO];
      // input pin is a plain io only for internal oscillator modes
      osc_in_pin_is_io <= cfg_ff[2:1] == 2'h2;
      // output pin is io in ec, and the no-clkout internal/rc modes
      osc_out_pin_is_io <= cfg_ff[2:0] == cwr_pkg::CWR_OSC_EC
        || cfg_ff[2:0] == cwr_pkg::CWR_OSC_INTIO
        || cfg_ff[2:0] == cwr_pkg::CWR_OSC_RESISTOR_CAP_OSC_NO_CLKOUT;
      clkout_enable <= cfg_ff[2:0] == cwr_pkg::CWR_OSC_INTCLK
        || cfg_ff[2:0] == cwr_pkg::CWR_OSC_RCCLK;
      internal_osc_stop <= pin_rst_ff && cwr_is_int_or_rc(cfg_ff[2:0]);
      pin_pullup_enable <= cfg_ff[cwr_pkg::PIN_EN_BIT];
      pin_reset_drive_oe_n <= 1'b1;
      pin_digital_in <= cfg_ff[cwr_pkg::PIN_EN_BIT] ? 1'b1 : pin_sync_ff[1];
      calib_word <= cal_ff;
      chip_reset_n <= rel_ff[cwr_pkg::REL_STAGES-1] && !src_rst;
      wake_resume <= wake_ff;
      timeout_flag_n <= to_ff;
      powerdown_flag_n <= pd_ff;
      por_flag_n <= por_ff;
      reset_kind <= kind_ff;
    end
  end

endmodule : cwr_config_reset
`default_nettype wire

// >>> verif/cwr_pin_drv.sv
// board driver model for the shared reset pin
// assumes pullup_en follows the device's weak pull-up output
`timescale 1ns/100ps
`default_nettype none
module cwr_pin_drv (
  input wire logic sys_clk,
  input wire logic pull_low,
  input wire logic pullup_en,
  output logic pin
);
  logic float_ff = 1'b0; // level of an undriven, unpulled pin
  // an open pin wanders, so it toggles rather than holding a guess
  always_ff @(posedge sys_clk)
  begin
    float_ff <= ~float_ff;
  end
  // released pin rests on the weak pull-up only when enabled
  assign pin = pull_low ? 1'b0 : (pullup_en ? 1'b1 : float_ff);
endmodule : cwr_pin_drv
`default_nettype wire

// >>> verif/cwr_config_reset_chk.sv
// port checker for the configuration decode and reset combiner
// assumes one clock domain and a bind onto cwr_config_reset
`timescale 1ns/100ps
`default_nettype none
module cwr_config_reset_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  input wire logic prog_bulk_erase,
  input wire logic shared_input_pin,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic clock_fail_monitor_enable,
  input wire logic data_read_protect,
  input wire logic powerup_delay_enable,
  input wire logic [2:0] clock_mode,
  input wire logic pin_reset_drive_oe_n,
  input wire logic [13:0] calib_word,
  input wire logic chip_reset_n,
  input wire logic wake_resume
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic cfg_wr; // programmer write to the configuration word
  logic [7:0] low_cnt_ff; // consecutive low pin samples, saturating
  logic [7:0] src_hist_ff; // recent watchdog or brown-out activity
  assign cfg_wr = prog_we && prog_addr == 16'h2007;
  // a counter, since forty cycles is too long for a repetition
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt_ff <= 8'h00;
    else if (shared_input_pin)
      low_cnt_ff <= 8'h00;
    else if (low_cnt_ff != 8'hff)
      low_cnt_ff <= low_cnt_ff + 8'h01;
  end
  // history masks falls caused by the other sources
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      src_hist_ff <= 8'h00;
    else
      src_hist_ff <= {src_hist_ff[6:0], watchdog_timeout | brownout_detect};
  end
  property p_fcm;
    cfg_wr |-> ##2 clock_fail_monitor_enable == $past(prog_wdata[11], 2);
  endproperty
  a_fcm: assert property (p_fcm) else $error("fail monitor enable wrong");
  property p_dprot;
    cfg_wr |-> ##2 data_read_protect == !$past(prog_wdata[7], 2);
  endproperty
  a_dprot: assert property (p_dprot) else $error("data protect wrong");
  property p_powerup_delay_timer;
    cfg_wr |-> ##2 powerup_delay_enable == !$past(prog_wdata[4], 2);
  endproperty
  a_powerup_delay_timer: assert property (p_powerup_delay_timer) else $error("power-up delay enable wrong");
  property p_mode;
    cfg_wr |-> ##2 clock_mode == $past(prog_wdata[2:0], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("clock mode wrong");
  property p_oe;
    watchdog_timeout |-> pin_reset_drive_oe_n [*8];
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven on watchdog");
  property p_calib;
    prog_bulk_erase |-> ##2 calib_word == $past(calib_word, 2);
  endproperty
  a_calib: assert property (p_calib) else $error("calibration lost on erase");
  property p_filter;
    $fell(chip_reset_n) && src_hist_ff == 8'h00 |-> low_cnt_ff >= 8'h28;
  endproperty
  a_filter: assert property (p_filter) else $error("short pin pulse reset");
  property p_wake;
    wake_resume |-> chip_reset_n ##1 chip_reset_n;
  endproperty
  a_wake: assert property (p_wake) else $error("reset on wake");
endmodule : cwr_config_reset_chk
bind cwr_config_reset cwr_config_reset_chk u_chk (.*);
`default_nettype wire

// >>> verif/tb.sv
// bench: programmer tasks, reset sources and a reference model
// assumes the pin driver model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, prog_we = 1'b0, prog_bulk_erase = 1'b0, pin_low = 1'b0;
  logic brownout_detect = 1'b0, watchdog_timeout = 1'b0, core_sleeping = 1'b0, status_clear = 1'b0;
  logic soft_brownout_enable = 1'b0, soft_watchdog_enable = 1'b0, por_flag_write = 1'b0, por_flag_wdata = 1'b0;
  logic [15:0] prog_addr = 16'h0000, prog_wdata = 16'h0000, prog_rdata;
  logic [13:0] calib_word;
  logic [2:0] clock_mode, reset_kind;
  logic shared_input_pin, clock_fail_monitor_enable, clock_switchover_enable, brownout_active, data_read_protect;
  logic prog_read_protect, data_eeprom_erase, powerup_delay_enable, watchdog_active, osc_in_pin_is_io;
  logic osc_out_pin_is_io, clkout_enable, internal_osc_stop, pin_pullup_enable, pin_reset_drive_oe_n;
  logic pin_digital_in, chip_reset_n, wake_resume, timeout_flag_n, powerdown_flag_n, por_flag_n;
  int fails = 0, compares = 0;
  int unsigned rng = 56;
  logic [15:0] cfg = 16'hffff, cal = 16'h3fff; // model of both words
  // event table: source 0 pin 1 watchdog 2 brown-out
  int src[8] = '{0, 0, 1, 2, 0, 1, 0, 2};
  int len[8] = '{30, 60, 4, 8, 60, 4, 60, 8};
  logic slp[8] = '{0, 0, 0, 0, 1, 1, 0, 0};
  logic rst[8] = '{0, 1, 1, 1, 1, 0, 0, 0};
  logic mto[8] = '{1, 1, 0, 1, 1, 0, 1, 1};
  logic mpd[8] = '{1, 1, 1, 1, 0, 0, 1, 1};
  cwr_config_reset dut (.*);
  cwr_pin_drv u_pin (.sys_clk(sys_clk), .pull_low(pin_low), .pullup_en(pin_pullup_enable), .pin(shared_input_pin));
  always #25 sys_clk = ~sys_clk;
  function automatic int unsigned rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  // expected decode from a word; programmed fuse reads zero
  function automatic logic [15:0] dec(input logic [15:0] c);
    logic [2:0] m;
    m = c[2:0];
    return {2'b00, c[11], c[10], c[9:8] == 2'h3 || (c[9:8] == 2'h2 && !core_sleeping) ||
      (c[9:8] == 2'h1 && soft_brownout_enable), !c[7], !c[6], !c[4], c[3] | soft_watchdog_enable, m,
      m[2:1] == 2'h2, m == 3'h3 || m == 3'h4 || m == 3'h6, m == 3'h5 || m == 3'h7, c[5]};
  endfunction : dec
  function automatic logic [15:0] got_dec();
    return {2'b00, clock_fail_monitor_enable, clock_switchover_enable, brownout_active, data_read_protect,
      prog_read_protect, powerup_delay_enable, watchdog_active, clock_mode, osc_in_pin_is_io, osc_out_pin_is_io,
      clkout_enable, pin_pullup_enable};
  endfunction : got_dec
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // one programmer write or bulk erase, then readback and decode
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic bulk);
    int er;
    logic exp_er;
    logic [15:0] m;
    er = 0;
    exp_er = bulk ? !cfg[7] : (a == 16'h2007 && !cfg[7] && d[7]);
    m = (a == 16'h2007) ? 16'h0fff : 16'h3fff;
    prog_addr = a;
    prog_wdata = d;
    prog_we = !bulk;
    prog_bulk_erase = bulk;
    @(negedge sys_clk);
    prog_we = 1'b0;
    prog_bulk_erase = 1'b0;
    if (bulk || a == 16'h2007)
      cfg = bulk ? 16'hffff : d;
    if (!bulk && a == 16'h2009)
      cal = {2'b00, d[13:0]};
    repeat (4)
    begin
      @(negedge sys_clk);
      er = er + int'(data_eeprom_erase === 1'b1);
    end
    chk(16'(er), {15'h0000, exp_er});
    chk(prog_rdata & m, (a == 16'h2007 ? cfg : (a == 16'h2009 ? cal : 16'h0000)) & m);
    chk({2'b00, calib_word}, cal);
    chk(got_dec(), dec(cfg));
  endtask : wr
  // one reset source from the table, flags cleared first
  task automatic ev(input int k);
    int low, osc, wk;
    logic wake;
    low = 0;
    osc = 0;
    wk = 0;
    wake = src[k] == 1 && slp[k];
    core_sleeping = slp[k];
    status_clear = 1'b1;
    @(negedge sys_clk);
    status_clear = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < len[k] + 60; i++)
    begin
      pin_low = src[k] == 0 && i < len[k];
      watchdog_timeout = src[k] == 1 && i < len[k];
      brownout_detect = src[k] == 2 && i < len[k];
      @(negedge sys_clk);
      low = low + int'(chip_reset_n === 1'b0);
      osc = osc + int'(internal_osc_stop === 1'b1);
      wk = wk + int'(wake_resume === 1'b1);
      if (src[k] == 0 && i == len[k] - 1)
        chk({15'h0000, pin_digital_in}, {15'h0000, cfg[5]});
    end
    chk({9'h000, low != 0, osc != 0, wk != 0, chip_reset_n, timeout_flag_n, powerdown_flag_n, por_flag_n},
      {9'h000, rst[k], rst[k] && src[k] == 0, wake, 1'b1, mto[k], mpd[k], 1'b1});
    if (rst[k] || wake)
      chk({13'h0000, reset_kind}, {13'h0000, src[k] == 2 ? 3'h1 : {slp[k], 1'b1, src[k] == 1}});
    $display("event case %0d done", k);
  endtask : ev
  initial
  begin
    logic [15:0] d;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({8'h00, chip_reset_n, timeout_flag_n, powerdown_flag_n, por_flag_n, 1'b0, reset_kind}, 16'h00e0);
    chk(got_dec(), dec(cfg));
    por_flag_write = 1'b1;
    por_flag_wdata = 1'b1;
    @(negedge sys_clk);
    por_flag_write = 1'b0;
    $display("reset test done");
    for (int i = 0; i < 13; i++)
    begin
      d = 16'(rnd());
      soft_brownout_enable = d[8];
      soft_watchdog_enable = d[12];
      d = 16'(rnd());
      d[7] = ~i[0];
      if (i < 8)
        d[2:0] = i[2:0];
      wr(i == 9 ? 16'h2009 : (i == 10 ? 16'h2008 : 16'h2007), d, i == 12);
    end
    $display("config test done");
    for (int k = 0; k < 8; k++)
    begin
      if (k == 6)
        wr(16'h2007, 16'h3cdf, 1'b0);
      ev(k);
    end
    end_sim();
  end
  initial
  begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
